// *** rtl/scc_pkg.sv ***
// Constants, strap decode tables and helpers of the conditioner config bank.
// Assumes strap levels arrive already resolved to small level numbers.
// Overview of operation
// - Transition gain code lives in bits 7-4, preset from strap, host writable.
// - Transition strap levels 0..3 load codes 0x0, 0x3, 0x6, 0x8.
// - Mode control bit 0: set means configuration hold, reads set after reset.
// - Static gain code lives in bits 3-0; bits 7-4 are reserved.
// - Static strap levels load 0x0, 0x2, 0x2, 0x6.
// - Receive gain code fills all eight bits, preset from tri-level strap.
// - Receive strap low, mid, high load 0x00, 0x44, 0x77.
// - Registers reached by standard-mode serial bus at target address 0x2C.
// - Serial controller enabled only if both lines sampled high after reset.
`default_nettype none
package scc_pkg;
  localparam logic [7:0] OFS_TRANS      = 8'h01;
  localparam logic [7:0] OFS_MODE       = 8'h03;
  localparam logic [7:0] OFS_STATIC     = 8'h0E;
  localparam logic [7:0] OFS_RECV       = 8'h25;
  localparam logic [7:0] UNMAPPED_DATA  = 8'h00;
  localparam logic [6:0] TARGET_ADDR    = 7'h2C;
  localparam logic [3:0] ADDR_RSV_LO    = 4'h0;
  localparam logic [3:0] ADDR_RSV_HI    = 4'hF;
  localparam int         TRANS_LSB      = 4;
  localparam int         STATIC_LSB     = 0;
  localparam int         HOLD_BIT       = 0;
  localparam logic [3:0] TRANS_RSV_RST  = 4'h0;
  localparam logic [3:0] STATIC_RSV_RST = 4'h0;
  localparam logic [7:0] MODE_RST       = 8'h01;
  localparam logic [7:0] TRANS_RST      = 8'h00;
  localparam logic [7:0] STATIC_RST     = 8'h00;
  localparam logic [7:0] RECV_RST       = 8'h00;
  localparam logic [1:0] RX_LOW         = 2'h0;
  localparam logic [1:0] RX_MID         = 2'h1;
  localparam logic [3:0] TG_L0 = 4'h0, TG_L1 = 4'h3, TG_L2 = 4'h6, TG_L3 = 4'h8;
  localparam logic [3:0] SG_L0 = 4'h0, SG_L12 = 4'h2, SG_L3 = 4'h6;
  localparam logic [7:0] RG_LOW = 8'h00, RG_MID = 8'h44, RG_HIGH = 8'h77;

  function automatic logic [3:0] trans_map(input logic [1:0] lvl);
    case (lvl)
      2'h0:    trans_map = TG_L0;
      2'h1:    trans_map = TG_L1;
      2'h2:    trans_map = TG_L2;
      default: trans_map = TG_L3;
    endcase
  endfunction

  function automatic logic [3:0] static_map(input logic [1:0] lvl);
    case (lvl)
      2'h0:       static_map = SG_L0;
      2'h1, 2'h2: static_map = SG_L12;
      default:    static_map = SG_L3;
    endcase
  endfunction

  // Code 3 on the tri-level strap is treated as high
  function automatic logic [7:0] recv_map(input logic [1:0] lvl);
    if (lvl == RX_LOW)
      recv_map = RG_LOW;
    else if (lvl == RX_MID)
      recv_map = RG_MID;
    else
      recv_map = RG_HIGH;
  endfunction
endpackage
`default_nettype wire

// *** rtl/scc_reg_if.sv ***
// Write strobe and read port between serial target and register bank.
// Assumes both ends run on ref_clk.
`default_nettype none
interface scc_reg_if;
  logic       wr_en;
  logic [7:0] wr_addr;
  logic [7:0] wr_data;
  logic [7:0] rd_addr;
  logic [7:0] rd_data;
  modport target (output wr_en, output wr_addr, output wr_data, output rd_addr,
                  input rd_data);
  modport bank   (input wr_en, input wr_addr, input wr_data, input rd_addr,
                  output rd_data);
endinterface
`default_nettype wire

// *** rtl/scc_reg_bank.sv ***
// Four configuration registers, three with strap preset, and host write port.
// Assumes load_straps is a single pulse right after reset release.
`default_nettype none
module scc_reg_bank
  import scc_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       reset,
  input  wire logic       load_straps,
  input  wire logic [1:0] gain_lvl,
  input  wire logic [1:0] rx_lvl,
  scc_reg_if.bank         rif,
  output logic      [7:0] trans_reg,
  output logic      [7:0] mode_reg,
  output logic      [7:0] static_reg,
  output logic      [7:0] recv_reg
);
  logic [7:0] trans_r, mode_r, static_r, recv_r;

  // Reserved bits return to their hardware value on each strap load
  always_ff @(posedge ref_clk) begin
    if (reset)
      trans_r <= TRANS_RST;
    else if (load_straps)
      trans_r <= {trans_map(gain_lvl), TRANS_RSV_RST};
    else if (rif.wr_en && rif.wr_addr == OFS_TRANS)
      trans_r <= rif.wr_data;
  end

  always_ff @(posedge ref_clk) begin
    if (reset)
      static_r <= STATIC_RST;
    else if (load_straps)
      static_r <= {STATIC_RSV_RST, static_map(gain_lvl)};
    else if (rif.wr_en && rif.wr_addr == OFS_STATIC)
      static_r <= rif.wr_data;
  end

  always_ff @(posedge ref_clk) begin
    if (reset)
      recv_r <= RECV_RST;
    else if (load_straps)
      recv_r <= recv_map(rx_lvl);
    else if (rif.wr_en && rif.wr_addr == OFS_RECV)
      recv_r <= rif.wr_data;
  end

  always_ff @(posedge ref_clk) begin
    if (reset)
      mode_r <= MODE_RST;
    else if (rif.wr_en && rif.wr_addr == OFS_MODE)
      mode_r <= rif.wr_data;
  end

  // Unmapped locations read as zero and ignore writes
  always_comb begin
    if (rif.rd_addr == OFS_TRANS)
      rif.rd_data = trans_r;
    else if (rif.rd_addr == OFS_MODE)
      rif.rd_data = mode_r;
    else if (rif.rd_addr == OFS_STATIC)
      rif.rd_data = static_r;
    else if (rif.rd_addr == OFS_RECV)
      rif.rd_data = recv_r;
    else
      rif.rd_data = UNMAPPED_DATA;
  end

  assign trans_reg  = trans_r;
  assign mode_reg   = mode_r;
  assign static_reg = static_r;
  assign recv_reg   = recv_r;

  property p_trans_load;
    @(posedge ref_clk) disable iff (reset)
    load_straps |=> trans_r == {trans_map($past(gain_lvl)), TRANS_RSV_RST};
  endproperty
  a_trans_load: assert property (p_trans_load)
    else $error("transition code not loaded from strap");

  property p_static_load;
    @(posedge ref_clk) disable iff (reset)
    load_straps |=> static_r[3:0] == static_map($past(gain_lvl));
  endproperty
  a_static_load: assert property (p_static_load)
    else $error("static code not loaded from strap");

  property p_recv_load;
    @(posedge ref_clk) disable iff (reset)
    load_straps |=> recv_r == recv_map($past(rx_lvl));
  endproperty
  a_recv_load: assert property (p_recv_load)
    else $error("receive code not loaded from strap");

  property p_trans_write;
    @(posedge ref_clk) disable iff (reset)
    rif.wr_en && rif.wr_addr == OFS_TRANS && !load_straps |=> trans_r == $past(rif.wr_data);
  endproperty
  a_trans_write: assert property (p_trans_write)
    else $error("transition register write lost");

  property p_static_write;
    @(posedge ref_clk) disable iff (reset)
    rif.wr_en && rif.wr_addr == OFS_STATIC && !load_straps
      |=> static_r == $past(rif.wr_data);
  endproperty
  a_static_write: assert property (p_static_write)
    else $error("static register write lost");

  property p_recv_write;
    @(posedge ref_clk) disable iff (reset)
    rif.wr_en && rif.wr_addr == OFS_RECV && !load_straps |=> recv_r == $past(rif.wr_data);
  endproperty
  a_recv_write: assert property (p_recv_write)
    else $error("receive register write lost");

  property p_hold_after_reset;
    @(posedge ref_clk) disable iff (reset)
    $past(reset) |-> mode_r[HOLD_BIT] ##1 mode_r[HOLD_BIT];
  endproperty
  a_hold_after_reset: assert property (p_hold_after_reset)
    else $error("hold bit not set after reset");

  property p_keep_codes;
    @(posedge ref_clk) disable iff (reset)
    !rif.wr_en && !load_straps |=> $stable(trans_r) && $stable(static_r) && $stable(recv_r);
  endproperty
  a_keep_codes: assert property (p_keep_codes)
    else $error("code changed without load or write");
endmodule
`default_nettype wire

// *** rtl/scc_config_top.sv ***
// Top of the conditioner config bank: serial target, strap capture, outputs.
// Assumes scl, sda and straps are asynchronous pins; sda is open drain.
`default_nettype none
module scc_config_top
  import scc_pkg::*;
#(
  parameter logic [6:0] I2C_ADDR = TARGET_ADDR
)(
  input  wire logic       ref_clk,
  input  wire logic       reset,
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe,
  input  wire logic [1:0] gain_strap,
  input  wire logic [1:0] rx_strap,
  output logic      [3:0] transition_gain_code,
  output logic      [3:0] static_gain_code,
  output logic      [7:0] receive_gain_code,
  output logic            config_hold,
  output logic            serial_mode_en
);
  typedef enum logic [3:0] {
    ST_IDLE, ST_ADDR, ST_ACK_A, ST_REG, ST_ACK_R,
    ST_WDATA, ST_ACK_W, ST_RDATA, ST_MACK
  } scc_state_t;

  generate
    if (I2C_ADDR[6:3] == ADDR_RSV_LO || I2C_ADDR[6:3] == ADDR_RSV_HI) begin : g_chk
      $error("target address falls in a reserved group");
    end
  endgenerate

  scc_reg_if rif ();

  logic [5:0] pin_m_r, pin_s_r;
  logic       scl_q_r, sda_q_r;
  logic       started_r, serial_en_r;
  scc_state_t state_r;
  logic [2:0] cnt_r;
  logic       full_r, rw_r, nack_r, drive_low_r;
  logic [7:0] shift_r, tx_r, ptr_r;
  logic       wr_en_r;
  logic [7:0] wr_addr_r, wr_data_r;
  logic [7:0] trans_reg, mode_reg, static_reg, recv_reg;
  logic       scl_s, sda_s, load_straps;
  logic       scl_rise, scl_fall, start_c, stop_c, wr_take;

  // Pins are not reset so they are already settled when reset lets go
  always_ff @(posedge ref_clk) begin
    pin_m_r <= {scl_i, sda_i, gain_strap, rx_strap};
    pin_s_r <= pin_m_r;
  end

  assign scl_s = pin_s_r[5];
  assign sda_s = pin_s_r[4];

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      scl_q_r <= 1'b1;
      sda_q_r <= 1'b1;
    end else begin
      scl_q_r <= scl_s;
      sda_q_r <= sda_s;
    end
  end

  assign scl_rise = scl_s && !scl_q_r;
  assign scl_fall = !scl_s && scl_q_r;
  assign start_c  = scl_s && scl_q_r && !sda_s && sda_q_r;
  assign stop_c   = scl_s && scl_q_r && sda_s && !sda_q_r;

  // One-shot after release: straps and serial-mode sense happen once
  always_ff @(posedge ref_clk) begin
    if (reset)
      started_r <= 1'b0;
    else
      started_r <= 1'b1;
  end

  assign load_straps = !started_r;

  always_ff @(posedge ref_clk) begin
    if (reset)
      serial_en_r <= 1'b0;
    else if (load_straps)
      serial_en_r <= scl_s && sda_s;
  end

  // Byte engine; a start or stop anywhere restarts the framing
  always_ff @(posedge ref_clk) begin
    if (reset || !serial_en_r) begin
      state_r     <= ST_IDLE;
      cnt_r       <= 3'h0;
      full_r      <= 1'b0;
      rw_r        <= 1'b0;
      nack_r      <= 1'b0;
      drive_low_r <= 1'b0;
      shift_r     <= 8'h00;
      tx_r        <= 8'h00;
      ptr_r       <= 8'h00;
    end else if (start_c) begin
      state_r     <= ST_ADDR;
      cnt_r       <= 3'h0;
      full_r      <= 1'b0;
      drive_low_r <= 1'b0;
    end else if (stop_c) begin
      state_r     <= ST_IDLE;
      drive_low_r <= 1'b0;
    end else if (scl_rise) begin
      case (state_r)
        ST_ADDR, ST_REG, ST_WDATA: begin
          shift_r <= {shift_r[6:0], sda_s};
          cnt_r   <= cnt_r + 3'h1;
          full_r  <= cnt_r == 3'h7;
        end
        ST_RDATA: begin
          cnt_r  <= cnt_r + 3'h1;
          full_r <= cnt_r == 3'h7;
        end
        ST_MACK: nack_r <= sda_s;
        default: ;
      endcase
    end else if (scl_fall) begin
      case (state_r)
        ST_ADDR: if (full_r) begin
          full_r <= 1'b0;
          if (shift_r[7:1] == I2C_ADDR) begin
            rw_r        <= shift_r[0];
            drive_low_r <= 1'b1;
            state_r     <= ST_ACK_A;
          end else begin
            state_r <= ST_IDLE;
          end
        end
        ST_ACK_A: begin
          if (rw_r) begin
            tx_r        <= rif.rd_data;
            drive_low_r <= !rif.rd_data[7];
            state_r     <= ST_RDATA;
          end else begin
            drive_low_r <= 1'b0;
            state_r     <= ST_REG;
          end
        end
        ST_REG: if (full_r) begin
          ptr_r       <= shift_r;
          full_r      <= 1'b0;
          drive_low_r <= 1'b1;
          state_r     <= ST_ACK_R;
        end
        ST_ACK_R: begin
          drive_low_r <= 1'b0;
          state_r     <= ST_WDATA;
        end
        ST_WDATA: if (full_r) begin
          full_r      <= 1'b0;
          drive_low_r <= 1'b1;
          state_r     <= ST_ACK_W;
        end
        ST_ACK_W: begin
          drive_low_r <= 1'b0;
          ptr_r       <= ptr_r + 8'h01;
          state_r     <= ST_WDATA;
        end
        ST_RDATA: begin
          if (full_r) begin
            full_r      <= 1'b0;
            drive_low_r <= 1'b0;
            ptr_r       <= ptr_r + 8'h01;
            state_r     <= ST_MACK;
          end else begin
            tx_r        <= {tx_r[6:0], 1'b0};
            drive_low_r <= !tx_r[6];
          end
        end
        ST_MACK: begin
          if (nack_r) begin
            state_r <= ST_IDLE;
          end else begin
            tx_r        <= rif.rd_data;
            drive_low_r <= !rif.rd_data[7];
            state_r     <= ST_RDATA;
          end
        end
        default: ;
      endcase
    end
  end

  assign wr_take = serial_en_r && !start_c && !stop_c && scl_fall
                   && state_r == ST_WDATA && full_r;

  // Registered strobe keeps the bank write one cycle off the pin edge
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      wr_en_r   <= 1'b0;
      wr_addr_r <= 8'h00;
      wr_data_r <= 8'h00;
    end else begin
      wr_en_r <= wr_take;
      if (wr_take) begin
        wr_addr_r <= ptr_r;
        wr_data_r <= shift_r;
      end
    end
  end

  assign rif.wr_en   = wr_en_r;
  assign rif.wr_addr = wr_addr_r;
  assign rif.wr_data = wr_data_r;
  assign rif.rd_addr = ptr_r;

  scc_reg_bank u_bank (
    .ref_clk     (ref_clk),
    .reset       (reset),
    .load_straps (load_straps),
    .gain_lvl    (pin_s_r[3:2]),
    .rx_lvl      (pin_s_r[1:0]),
    .rif         (rif.bank),
    .trans_reg   (trans_reg),
    .mode_reg    (mode_reg),
    .static_reg  (static_reg),
    .recv_reg    (recv_reg)
  );

  // Open drain: only ever pulls low
  assign sda_o                = 1'b0;
  assign sda_oe               = drive_low_r;
  assign transition_gain_code = trans_reg[TRANS_LSB +: 4];
  assign static_gain_code     = static_reg[STATIC_LSB +: 4];
  assign receive_gain_code    = recv_reg;
  assign config_hold          = mode_reg[HOLD_BIT];
  assign serial_mode_en       = serial_en_r;

  property p_silent_no_serial;
    @(posedge ref_clk) disable iff (reset)
    !serial_en_r |=> !sda_oe && !rif.wr_en;
  endproperty
  a_silent_no_serial: assert property (p_silent_no_serial)
    else $error("serial port active while disabled");

  property p_addr_ack;
    @(posedge ref_clk) disable iff (reset)
    serial_en_r && !start_c && !stop_c && scl_fall && state_r == ST_ADDR && full_r
      && shift_r[7:1] == I2C_ADDR |=> sda_oe && state_r == ST_ACK_A;
  endproperty
  a_addr_ack: assert property (p_addr_ack)
    else $error("own address not acknowledged");

  property p_foreign_addr;
    @(posedge ref_clk) disable iff (reset)
    serial_en_r && !start_c && !stop_c && scl_fall && state_r == ST_ADDR && full_r
      && shift_r[7:1] != I2C_ADDR |=> !sda_oe ##1 !sda_oe;
  endproperty
  a_foreign_addr: assert property (p_foreign_addr)
    else $error("foreign address acknowledged");

  property p_write_from_data;
    @(posedge ref_clk) disable iff (reset)
    rif.wr_en |-> $past(state_r) == ST_WDATA && rif.wr_data == $past(shift_r)
      ##1 !rif.wr_en;
  endproperty
  a_write_from_data: assert property (p_write_from_data)
    else $error("write strobe without data byte");

  property p_mode_sense_once;
    @(posedge ref_clk) disable iff (reset)
    started_r |=> $stable(serial_en_r);
  endproperty
  a_mode_sense_once: assert property (p_mode_sense_once)
    else $error("serial mode changed after startup");
endmodule
`default_nettype wire

// *** testbench/scc_host_model.sv ***
// Serial bus host model that drives the config bank's clock and data pins.
// Assumes the bench resolves the open-drain data line with a pull-up.
`default_nettype none
module scc_host_model (
  input  wire logic clk,
  input  wire logic sda_line,
  output var logic  scl,
  output var logic  sda_low
);
  timeunit 1ns;
  timeprecision 100ps;

  // Quarter bit in clocks; 63 keeps the bus at or under 100 kHz
  int qtr = 16;

  initial begin
    scl     = 1'b1;
    sda_low = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // Data changes only while the clock is low, so no false start or stop
  task automatic bit_io(input logic b, output logic s);
    sda_low = !b;
    tick(qtr);
    scl = 1'b1;
    tick(qtr);
    s = sda_line;
    tick(qtr);
    scl = 1'b0;
    tick(qtr);
  endtask

  task automatic start_cond();
    sda_low = 1'b0;
    tick(qtr);
    scl = 1'b1;
    tick(qtr);
    sda_low = 1'b1;
    tick(qtr);
    scl = 1'b0;
    tick(qtr);
  endtask

  task automatic stop_cond();
    sda_low = 1'b1;
    tick(qtr);
    scl = 1'b1;
    tick(qtr);
    sda_low = 1'b0;
    tick(2 * qtr);
  endtask

  task automatic byte_io(input logic [7:0] d, input logic nak, output logic [7:0] q,
                         output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
    bit_io(nak, s);
    ack = !s;
  endtask

  task automatic wr_reg(input logic [6:0] dev, input logic [7:0] ofs, input logic [7:0] d,
                        output logic ok);
    logic [7:0] q;
    logic       a0, a1, a2;
    start_cond();
    byte_io({dev, 1'b0}, 1'b1, q, a0);
    byte_io(ofs, 1'b1, q, a1);
    byte_io(d, 1'b1, q, a2);
    stop_cond();
    ok = a0 & a1 & a2;
  endtask

  // Single byte read, ended by a NACK as the bus requires
  task automatic rd_reg(input logic [6:0] dev, input logic [7:0] ofs, output logic [7:0] d,
                        output logic ok);
    logic [7:0] q;
    logic       a0, a1, a2, na;
    start_cond();
    byte_io({dev, 1'b0}, 1'b1, q, a0);
    byte_io(ofs, 1'b1, q, a1);
    start_cond();
    byte_io({dev, 1'b1}, 1'b1, q, a2);
    byte_io(8'hFF, 1'b1, d, na);
    stop_cond();
    ok = a0 & a1 & a2;
  endtask

  // Two data bytes in one frame exercise the pointer increment
  task automatic wr_pair(input logic [6:0] dev, input logic [7:0] ofs, input logic [15:0] d,
                         output logic ok);
    logic [7:0] q;
    logic       a0, a1, a2, a3;
    start_cond();
    byte_io({dev, 1'b0}, 1'b1, q, a0);
    byte_io(ofs, 1'b1, q, a1);
    byte_io(d[15:8], 1'b1, q, a2);
    byte_io(d[7:0], 1'b1, q, a3);
    stop_cond();
    ok = a0 & a1 & a2 & a3;
  endtask

  // Host acknowledges the first byte so the target goes on to the next
  task automatic rd_pair(input logic [6:0] dev, input logic [7:0] ofs, output logic [15:0] d,
                         output logic ok);
    logic [7:0] q;
    logic       a0, a1, a2, na;
    start_cond();
    byte_io({dev, 1'b0}, 1'b1, q, a0);
    byte_io(ofs, 1'b1, q, a1);
    start_cond();
    byte_io({dev, 1'b1}, 1'b1, q, a2);
    byte_io(8'hFF, 1'b0, d[15:8], na);
    byte_io(8'hFF, 1'b1, d[7:0], na);
    stop_cond();
    ok = a0 & a1 & a2;
  endtask
endmodule
`default_nettype wire

// *** testbench/signal_conditioner_config_regs_tb.sv ***
// Self-checking bench for the conditioner config bank top.
// Assumes the host model and the design package are compiled first.
`default_nettype none
module signal_conditioner_config_regs_tb
  import scc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  typedef struct packed {
    logic [1:0] g;
    logic [1:0] r;
    logic [3:0] t;
    logic [3:0] s;
    logic [7:0] x;
  } scc_row_t;

  logic       ref_clk    = 1'b0;
  logic       reset      = 1'b1;
  logic [1:0] gain_strap = 2'h0;
  logic [1:0] rx_strap   = 2'h0;
  logic       scl;
  logic       host_low;
  logic       sda_line;
  logic       sda_o;
  logic       sda_oe;
  logic       config_hold;
  logic       serial_mode_en;
  logic [3:0] transition_gain_code;
  logic [3:0] static_gain_code;
  logic [7:0] receive_gain_code;
  logic [7:0] rd;
  logic [15:0] pair;
  logic       ok;
  int         num_errors  = 0;
  int         check_count = 0;
  scc_row_t   rows [4] = '{'{2'h0, 2'h0, 4'h0, 4'h0, 8'h00}, '{2'h1, 2'h1, 4'h3, 4'h2, 8'h44},
                           '{2'h2, 2'h2, 4'h6, 4'h2, 8'h77}, '{2'h3, 2'h3, 4'h8, 4'h6, 8'h77}};

  always #20 ref_clk = ~ref_clk;
  // Pull-up wins unless some party pulls low
  assign sda_line = !(host_low || (sda_oe && !sda_o));

  scc_config_top #(.I2C_ADDR(TARGET_ADDR)) i_scc_config_top (
    .ref_clk(ref_clk), .reset(reset), .scl_i(scl), .sda_i(sda_line), .sda_o(sda_o),
    .sda_oe(sda_oe), .gain_strap(gain_strap), .rx_strap(rx_strap),
    .transition_gain_code(transition_gain_code), .static_gain_code(static_gain_code),
    .receive_gain_code(receive_gain_code), .config_hold(config_hold),
    .serial_mode_en(serial_mode_en));

  scc_host_model i_scc_host_model (.clk(ref_clk), .sda_line(sda_line), .scl(scl),
                                   .sda_low(host_low));

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic final_report();
    $display("Checks made %0d, mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic do_reset(input logic [1:0] g, input logic [1:0] r);
    @(posedge ref_clk);
    #1;
    reset      = 1'b1;
    gain_strap = g;
    rx_strap   = r;
    repeat (5) @(posedge ref_clk);
    #1;
    check({config_hold, sda_oe, serial_mode_en, sda_o, 4'h0}, 8'h80);
    check({transition_gain_code, static_gain_code}, 8'h00);
    @(posedge ref_clk);
    #1;
    reset = 1'b0;
    repeat (3) @(posedge ref_clk);
    #1;
  endtask

  task automatic wr(input logic [7:0] ofs, input logic [7:0] d);
    i_scc_host_model.wr_reg(TARGET_ADDR, ofs, d, ok);
    check({7'h00, ok}, 8'h01);
  endtask

  task automatic rd_chk(input logic [7:0] ofs, input logic [7:0] exp);
    i_scc_host_model.rd_reg(TARGET_ADDR, ofs, rd, ok);
    check({7'h00, ok}, 8'h01);
    check(rd, exp);
  endtask

  initial begin
    repeat (90000) @(posedge ref_clk);
    num_errors++;
    final_report();
  end

  initial begin
    foreach (rows[i]) begin
      do_reset(rows[i].g, rows[i].r);
      check({4'h0, transition_gain_code}, {4'h0, rows[i].t});
      check({4'h0, static_gain_code}, {4'h0, rows[i].s});
      check(receive_gain_code, rows[i].x);
      check({6'h00, serial_mode_en, config_hold}, 8'h03);
    end
    $display("test strap decode done");
    do_reset(2'h1, 2'h1);
    i_scc_host_model.qtr = 63;
    rd_chk(OFS_MODE, 8'h01);
    i_scc_host_model.qtr = 16;
    rd_chk(OFS_TRANS, 8'h30);
    rd_chk(OFS_STATIC, 8'h02);
    rd_chk(OFS_RECV, 8'h44);
    $display("test register presets done");
    wr(OFS_MODE, 8'h01);
    // Reserved bits are read first and written back untouched
    i_scc_host_model.rd_reg(TARGET_ADDR, OFS_TRANS, rd, ok);
    wr(OFS_TRANS, {4'hF, rd[3:0]});
    check({4'h0, transition_gain_code}, 8'h0F);
    i_scc_host_model.rd_reg(TARGET_ADDR, OFS_STATIC, rd, ok);
    wr(OFS_STATIC, {rd[7:4], 4'hF});
    check({4'h0, static_gain_code}, 8'h0F);
    wr(OFS_RECV, 8'hFF);
    check(receive_gain_code, 8'hFF);
    rd_chk(OFS_TRANS, 8'hF0);
    $display("test host writes done");
    wr(OFS_MODE, 8'h00);
    check({7'h00, config_hold}, 8'h00);
    rd_chk(OFS_MODE, 8'h00);
    wr(OFS_MODE, 8'h01);
    check({7'h00, config_hold}, 8'h01);
    // Without the pointer increment the second byte would miss the mode register
    i_scc_host_model.wr_pair(TARGET_ADDR, 8'h02, 16'h5A00, ok);
    check({7'h00, ok}, 8'h01);
    check({7'h00, config_hold}, 8'h00);
    wr(OFS_MODE, 8'h01);
    i_scc_host_model.rd_pair(TARGET_ADDR, 8'h02, pair, ok);
    check({7'h00, ok}, 8'h01);
    check(pair[15:8], 8'h00);
    check(pair[7:0], 8'h01);
    $display("test mode control done");
    wr(8'h10, 8'h5A);
    rd_chk(8'h10, 8'h00);
    i_scc_host_model.wr_reg(TARGET_ADDR ^ 7'h01, OFS_RECV, 8'h11, ok);
    check({7'h00, ok}, 8'h00);
    check(receive_gain_code, 8'hFF);
    $display("test unmapped and foreign address done");
    do_reset(2'h1, 2'h1);
    check({transition_gain_code, static_gain_code}, 8'h32);
    check(receive_gain_code, 8'h44);
    $display("test strap reload done");
    i_scc_host_model.sda_low = 1'b1;
    do_reset(2'h2, 2'h0);
    check({7'h00, serial_mode_en}, 8'h00);
    check({transition_gain_code, static_gain_code}, 8'h62);
    i_scc_host_model.sda_low = 1'b0;
    i_scc_host_model.rd_reg(TARGET_ADDR, OFS_MODE, rd, ok);
    check({7'h00, ok}, 8'h00);
    $display("test serial port disabled done");
    final_report();
  end
endmodule
`default_nettype wire
